// ===== shared/hpio_consts.vh
// Constants for the host port and I/O control block
`ifndef HPIO_CONSTS_VH
`define HPIO_CONSTS_VH
// APB register byte offsets
`define HPIO_OFF_CTRL     12'h000
`define HPIO_OFF_DOR      12'h004
`define HPIO_OFF_PC       12'h008
`define HPIO_OFF_STATUS   12'h00c
`define HPIO_OFF_FIFO     12'h010
`define HPIO_OFF_AOR      12'h014
`define HPIO_OFF_ADDRCNT  12'h018
`define HPIO_OFF_BLKCNT   12'h01c
`define HPIO_OFF_OUTCTL   12'h020
`define HPIO_OFF_ADDRIN   12'h024
`define HPIO_OFF_DATAIN   12'h028
// Control word bit positions
`define HPIO_CTRL_ADDR_COUNT_EN    0
`define HPIO_CTRL_BLOCK_COUNT_EN    1
`define HPIO_CTRL_HOST_DATA_OUT_EN    2
`define HPIO_CTRL_HOST_ADDR_OUT_EN   3
`define HPIO_CTRL_ADDR_BUS_OUT_EN    4
`define HPIO_CTRL_SEL0    5
`define HPIO_CTRL_SEL1    6
`define HPIO_CTRL_DATA_IN_REG_WRITE_EN   7
`define HPIO_CTRL_ADDR_IN_REG_WRITE_EN   8
`define HPIO_CTRL_ADDR_BUS_SOURCE_SEL    9
`define HPIO_CTRL_EXT     10
// Reset values
`define HPIO_CTRL_RST     11'h000
// Host pin synchroniser reset: cs, rd and wr strobes inactive
`define HPIO_SYNC_RST     25'h0000007
// Host register select codes
`define HPIO_HREG_DOR     5'h00
`define HPIO_HREG_STATUS  5'h01
`define HPIO_HREG_PC      5'h02
`define HPIO_HREG_CLRST   5'h03
`define HPIO_HREG_CLRFIFO 5'h04
// Status bit positions
`define HPIO_ST_ACO       0
`define HPIO_ST_BCZ       1
`define HPIO_ST_FIFO_INPUT_READY      8
`define HPIO_ST_FIOR      12
`endif

// ===== hw/hpio_top.v
// Host port and I/O control block with APB register access
//
// What this block does
// [RULE1] Host write with tag low pushes data and register select into FIFO
// [RULE2] Host write with tag high pushes data into FIFO marked as command
// [RULE3] Host read strobe at select 00100 clears the FIFO
// [RULE4] Host read strobe at select 00011 clears the status register
// [RULE5] Host read strobe drives status, program counter or data output register
// [RULE6] Idle strobes with nonzero source select drive chosen source on host data
// [RULE7] Control bit 9 picks address counter or address output register
// [RULE8] Control bit 8 gates loading of address input register from bus
// [RULE9] Control bit 7 gates writing of the data input register
// [RULE10] Control bits 6 and 5 choose host data bus source
// [RULE11] Control bit 4 sets external address bus direction
// [RULE12] Control bit 3 sets host address bus direction
// [RULE13] Control bit 2 sets host data direction for next cycle
// [RULE14] Control bit 1 enables the block counter
// [RULE15] Control bit 0 enables the address counter
// [RULE16] Address counter has six-bit low and sixteen-bit high parts
// [RULE17] Enabled high counter increments every edge, sixteen bits by default
// [RULE18] Extended flag joins both parts into one twenty-two-bit counter
// [RULE19] Set, clear and loads of counter registers change counting
// [RULE20] Sixteen output control lines settable every cycle
// [RULE21] Command entry gives low ten bits as next microcode address
// [RULE22] FIFO input-ready high while at least one location vacant
// [RULE23] Unlisted host strobe combinations push, clear and drive nothing
`timescale 1ns/1ps
`include "hpio_consts.vh"
module hpio_top #(
  parameter DEPTH_LOG2 = 3
) (
  // Clock, enable and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Host strobes, active low
  input  wire        host_cs_n,
  input  wire        host_rd_n,
  input  wire        host_wr_n,
  // Host address lines
  input  wire        host_cmd_tag_line,
  input  wire [4:0]  host_reg_select,
  output wire [5:0]  host_addr_o,
  output wire        host_addr_out_en,
  // Host data lines
  input  wire [15:0] host_data_lines,
  output reg  [15:0] host_data_o,
  output reg         host_data_out_en,
  // External address bus
  input  wire [15:0] addr_bus_i,
  output reg  [15:0] addr_bus_o,
  output wire        addr_bus_out_en,
  // Internal status and program counter
  input  wire [15:0] status_in,
  input  wire [15:0] pc_in,
  // FIFO drain side for the sequencer
  input  wire        fifo_pop,
  output wire [15:0] fifo_data,
  output wire [4:0]  fifo_reg_addr,
  output wire        fifo_cmd_data_tag,
  output wire        fifo_out_ready,
  output wire [9:0]  cmd_next_addr,
  output wire        cmd_valid,
  output wire        fifo_input_ready,
  // Output control lines
  output reg  [15:0] out_ctrl_lines
);

  localparam DEPTH = 1 << DEPTH_LOG2;

  // Control and data registers
  reg [10:0] ctrl_r;
  reg [15:0] data_out_reg;
  reg [15:0] addr_out_reg;
  reg [15:0] addr_in_r;
  reg [15:0] data_in_r;
  reg [5:0]  addr_count_low;
  reg [15:0] addr_count_high;
  reg [15:0] block_counter;
  reg [15:0] status_clr_r;
  reg [21:0] fifo_mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wr_ptr_r;
  reg [DEPTH_LOG2:0] rd_ptr_r;

  // Host pins pass two flip-flops; strobes reset to their inactive level
  wire [24:0] sync_pins;
  wire        hwr_act;
  reg         hwr_d_r;
  hpio_sync2 #(
    .WIDTH   (25),
    .RST     (`HPIO_SYNC_RST)
  ) hpio_sync2_i (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       ({host_data_lines, host_cmd_tag_line, host_reg_select, host_cs_n, host_rd_n, host_wr_n}),
    .q       (sync_pins)
  );

  // Delayed write decode, so one held strobe pushes only once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hwr_d_r <= 1'b0;
    else if (clk_en)
      hwr_d_r <= hwr_act;
  end

  wire        s_wr_n  = sync_pins[0];
  wire        s_rd_n  = sync_pins[1];
  wire        s_cs_n  = sync_pins[2];
  wire [4:0]  s_sel   = sync_pins[7:3];
  wire        s_tag   = sync_pins[8];
  wire [15:0] s_data  = sync_pins[24:9];
  wire        sel0    = ctrl_r[`HPIO_CTRL_SEL0];
  wire        sel1    = ctrl_r[`HPIO_CTRL_SEL1];
  wire        periph  = !sel0 && !sel1;

  // Host strobe decode
  assign hwr_act = periph && !s_cs_n && s_rd_n && !s_wr_n; // RULE1 RULE2
  wire hrd_act = periph && !s_cs_n && !s_rd_n && s_wr_n && !s_tag;
  wire idle    = s_cs_n && s_rd_n && s_wr_n;
  wire push    = hwr_act && !hwr_d_r;                      // RULE23
  wire fifo_clr = hrd_act && (s_sel == `HPIO_HREG_CLRFIFO); // RULE3
  wire st_clr   = hrd_act && (s_sel == `HPIO_HREG_CLRST);   // RULE4

  // FIFO status
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire full  = (wr_ptr_r[DEPTH_LOG2] != rd_ptr_r[DEPTH_LOG2]) &&
               (wr_ptr_r[DEPTH_LOG2-1:0] == rd_ptr_r[DEPTH_LOG2-1:0]);
  assign fifo_input_ready = !full;                           // RULE22
  assign fifo_out_ready   = !empty;
  wire [21:0] head = fifo_mem[rd_ptr_r[DEPTH_LOG2-1:0]];
  assign fifo_data         = head[15:0];
  assign fifo_reg_addr     = head[20:16];
  assign fifo_cmd_data_tag = head[21];
  assign cmd_valid         = !empty && head[21];
  assign cmd_next_addr     = head[9:0];                      // RULE21

  // FIFO write and read pointers; clear has priority
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
      rd_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
    end else if (clk_en) begin
      if (fifo_clr) begin                                    // RULE3
        wr_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
        rd_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
      end else begin
        if (push && !full)
          wr_ptr_r <= wr_ptr_r + 1'b1;
        if (fifo_pop && !empty)
          rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // FIFO storage, command entries ignore the register select
  always @(posedge pclk) begin
    if (clk_en && push && !full && !fifo_clr) begin
      if (s_tag)
        fifo_mem[wr_ptr_r[DEPTH_LOG2-1:0]] <= {1'b1, 5'h00, s_data};      // RULE2
      else
        fifo_mem[wr_ptr_r[DEPTH_LOG2-1:0]] <= {1'b0, s_sel, s_data};      // RULE1
    end
  end

  // Status view: external bits, live FIFO flags, sticky clear mask
  wire        addr_cnt_full = ({addr_count_high, addr_count_low} == 22'h3fffff);
  wire        blk_cnt_zero  = (block_counter == 16'h0000);
  wire [15:0] status_raw    = {3'h0, !empty, 3'h0, !full, status_in[7:2], blk_cnt_zero, addr_cnt_full};
  wire [15:0] status_view = status_raw & ~status_clr_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status_clr_r <= 16'h0000;
    else if (clk_en) begin
      if (st_clr)                                            // RULE4
        status_clr_r <= status_raw;
      else
        status_clr_r <= status_clr_r & status_raw;           // New sets win once source drops
    end
  end

  // Host data source: read strobes first, then idle drive from the chosen source
  reg [15:0] host_data_nxt;
  reg        host_oe_nxt;
  always @* begin
    host_data_nxt = 16'h0000;
    host_oe_nxt   = 1'b0;
    if (hrd_act) begin
      case (s_sel)
        `HPIO_HREG_STATUS: begin                             // RULE5
          host_data_nxt = status_view;
          host_oe_nxt   = 1'b1;
        end
        `HPIO_HREG_PC: begin                                 // RULE5
          host_data_nxt = pc_in;
          host_oe_nxt   = 1'b1;
        end
        `HPIO_HREG_DOR: begin                                // RULE5
          host_data_nxt = data_out_reg;
          host_oe_nxt   = 1'b1;
        end
        default: begin                                       // RULE23
          host_data_nxt = 16'h0000;
          host_oe_nxt   = 1'b0;
        end
      endcase
    end else if (idle && !periph) begin                      // RULE6 RULE10
      case ({sel1, sel0})
        2'b01:   host_data_nxt = data_out_reg;
        2'b10:   host_data_nxt = status_view;
        default: host_data_nxt = pc_in;
      endcase
      host_oe_nxt = ctrl_r[`HPIO_CTRL_HOST_DATA_OUT_EN];                 // RULE13
    end
  end

  // Host data outputs, registered so they turn one cycle after the decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_o      <= 16'h0000;
      host_data_out_en <= 1'b0;
    end else if (clk_en) begin
      host_data_o      <= host_data_nxt;
      host_data_out_en <= host_oe_nxt;
    end
  end

  // Bus directions and address source
  assign addr_bus_out_en  = ctrl_r[`HPIO_CTRL_ADDR_BUS_OUT_EN];         // RULE11
  assign host_addr_out_en = ctrl_r[`HPIO_CTRL_HOST_ADDR_OUT_EN];        // RULE12
  assign host_addr_o      = addr_count_low;
  always @* begin
    if (ctrl_r[`HPIO_CTRL_ADDR_BUS_SOURCE_SEL])                             // RULE7
      addr_bus_o = addr_count_high;
    else
      addr_bus_o = addr_out_reg;
  end

  // APB decode
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && !pwrite;
  assign pready  = 1'b1;
  wire   known   = (paddr[1:0] == 2'b00) && (paddr <= `HPIO_OFF_DATAIN);
  assign pslverr = psel && penable && !known;

  // Registers, counters and loads
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r          <= `HPIO_CTRL_RST;
      data_out_reg    <= 16'h0000;
      addr_out_reg    <= 16'h0000;
      addr_in_r       <= 16'h0000;
      data_in_r       <= 16'h0000;
      addr_count_low  <= 6'h00;
      addr_count_high <= 16'h0000;
      block_counter   <= 16'h0000;
      out_ctrl_lines  <= 16'h0000;
    end else if (clk_en) begin
      if (ctrl_r[`HPIO_CTRL_ADDR_IN_REG_WRITE_EN] && !ctrl_r[`HPIO_CTRL_ADDR_BUS_OUT_EN])
        addr_in_r <= addr_bus_i;                             // RULE8
      if (ctrl_r[`HPIO_CTRL_DATA_IN_REG_WRITE_EN])
        data_in_r <= s_data;                                 // RULE9
      if (ctrl_r[`HPIO_CTRL_BLOCK_COUNT_EN])
        block_counter <= block_counter - 1'b1;               // RULE14
      if (ctrl_r[`HPIO_CTRL_ADDR_COUNT_EN]) begin                     // RULE15 RULE17
        if (ctrl_r[`HPIO_CTRL_EXT])                          // RULE16 RULE18
          {addr_count_high, addr_count_low} <= {addr_count_high, addr_count_low} + 22'h000001;
        else
          addr_count_high <= addr_count_high + 16'h0001;
      end
      if (apb_wr && known) begin                             // RULE19 RULE20
        case (paddr)
          `HPIO_OFF_CTRL:    ctrl_r <= pwdata[10:0];
          `HPIO_OFF_DOR:     data_out_reg <= pwdata[15:0];
          `HPIO_OFF_AOR:     addr_out_reg <= pwdata[15:0];
          `HPIO_OFF_ADDRCNT: {addr_count_high, addr_count_low} <= pwdata[21:0];
          `HPIO_OFF_BLKCNT:  block_counter <= pwdata[15:0];
          `HPIO_OFF_OUTCTL:  out_ctrl_lines <= pwdata[15:0];
          default:           ;
        endcase
      end
    end
  end

  // Read data, registered in setup cycle for the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (clk_en && apb_rd) begin
      case (paddr)
        `HPIO_OFF_CTRL:    prdata <= {21'h000000, ctrl_r};
        `HPIO_OFF_DOR:     prdata <= {16'h0000, data_out_reg};
        `HPIO_OFF_PC:      prdata <= {16'h0000, pc_in};
        `HPIO_OFF_STATUS:  prdata <= {16'h0000, status_view};
        `HPIO_OFF_FIFO:    prdata <= {10'h000, head};
        `HPIO_OFF_AOR:     prdata <= {16'h0000, addr_out_reg};
        `HPIO_OFF_ADDRCNT: prdata <= {10'h000, addr_count_high, addr_count_low};
        `HPIO_OFF_BLKCNT:  prdata <= {16'h0000, block_counter};
        `HPIO_OFF_OUTCTL:  prdata <= {16'h0000, out_ctrl_lines};
        `HPIO_OFF_ADDRIN:  prdata <= {16'h0000, addr_in_r};
        `HPIO_OFF_DATAIN:  prdata <= {16'h0000, data_in_r};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // hpio_top

// Two-stage synchroniser for signals from outside the clock domain
module hpio_sync2 #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] RST   = {WIDTH{1'b0}}
) (
  // Clock, enable and reset
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clk_en,
  // Raw and synchronised signals
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  // First stage is read only by the second, to contain metastability
  reg [WIDTH-1:0] meta_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST;
      q      <= RST;
    end else if (clk_en) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // hpio_sync2

// ===== test/hpio_top_monitor.sv
// Checker for the host port and I/O control block
`timescale 1ns/1ps
module hpio_top_monitor (
  // Clock, reset and APB
  input wire        pclk, presetn, clk_en, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Host lines
  input wire        host_rd_n, host_wr_n, host_addr_out_en, host_data_out_en,
  input wire [5:0]  host_addr_o,
  // Address bus and FIFO head
  input wire [15:0] addr_bus_o, fifo_data,
  input wire        addr_bus_out_en, fifo_cmd_data_tag, fifo_out_ready, cmd_valid, fifo_input_ready,
  input wire [9:0]  cmd_next_addr
);
  reg  [10:0] ctl_r;
  reg  [15:0] aor_r;
  wire        wr  = psel & penable & pwrite & clk_en;
  wire        run = clk_en & ~wr & ctl_r[9];
  // Shadow of control word and address output register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 11'h000;
      aor_r <= 16'h0000;
    end else if (wr && paddr == 12'h000) begin
      ctl_r <= pwdata[10:0];
    end else if (wr && paddr == 12'h014) begin
      aor_r <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_adir; $stable(ctl_r) |-> addr_bus_out_en == ctl_r[4]; endproperty
  a_adir: assert property (p_adir) else $error("address bus direction wrong");
  property p_hdir; $stable(ctl_r) |-> host_addr_out_en == ctl_r[3]; endproperty
  a_hdir: assert property (p_hdir) else $error("host address direction wrong");
  property p_aor; $stable(ctl_r) && $stable(aor_r) && !ctl_r[9] |-> addr_bus_o == aor_r; endproperty
  a_aor: assert property (p_aor) else $error("address bus not from output register");
  property p_full; !fifo_input_ready |-> fifo_out_ready; endproperty
  a_full: assert property (p_full) else $error("input ready low on empty fifo");
  property p_cmd; cmd_valid |-> fifo_out_ready && fifo_cmd_data_tag && cmd_next_addr == fifo_data[9:0]; endproperty
  a_cmd: assert property (p_cmd) else $error("command address wrong");
  property p_quiet; (ctl_r[6:5] == 2'b00 && host_rd_n)[*4] |-> !host_data_out_en; endproperty
  a_quiet: assert property (p_quiet) else $error("host data driven without read");
  property p_push; $rose(fifo_out_ready) |-> $past(host_wr_n, 2) == 1'b0; endproperty
  a_push: assert property (p_push) else $error("fifo filled without write strobe");
  property p_cnt16; (run && ctl_r[0] && !ctl_r[10])[*2] |=> addr_bus_o == $past(addr_bus_o) + 16'h0001; endproperty
  a_cnt16: assert property (p_cnt16) else $error("high counter did not step");
  property p_cnt22;
    (run && ctl_r[0] && ctl_r[10])[*2] |=> {addr_bus_o, host_addr_o} == {$past(addr_bus_o), $past(host_addr_o)} + 22'h000001;
  endproperty
  a_cnt22: assert property (p_cnt22) else $error("joined counter did not step");
  property p_hold; (run && !ctl_r[0])[*2] |=> $stable(addr_bus_o) && $stable(host_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("counter moved while disabled");
endmodule // hpio_top_monitor
bind hpio_top hpio_top_monitor hpio_top_monitor_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata, .host_rd_n, .host_wr_n, .host_addr_out_en, .host_data_out_en, .host_addr_o, .addr_bus_o, .fifo_data,
  .addr_bus_out_en, .fifo_cmd_data_tag, .fifo_out_ready, .cmd_valid, .fifo_input_ready, .cmd_next_addr);

// ===== test/hpio_host_model.sv
// Host processor model on the asynchronous strobe bus
`timescale 1ns/1ps
module hpio_host_model (
  // Clock and read-back
  input wire        pclk, host_data_out_en,
  input wire [15:0] host_data_o,
  // Host strobes and lines
  output reg        host_cs_n, host_rd_n, host_wr_n, host_cmd_tag_line,
  output reg [4:0]  host_reg_select,
  output reg [15:0] host_data_lines
);
  // All strobes inactive from time zero
  initial {host_cs_n, host_rd_n, host_wr_n, host_cmd_tag_line, host_reg_select, host_data_lines} = 25'h1c00000;
  // One strobe held five cycles, sampled, then released four cycles
  task cyc(input r, input w, input t, input [4:0] s, input [15:0] d, output [15:0] q, output oe);
    @(posedge pclk);
    host_cs_n <= 1'b0;
    {host_rd_n, host_wr_n, host_cmd_tag_line, host_reg_select, host_data_lines} <= {r, w, t, s, d};
    repeat (5) @(posedge pclk);
    q = host_data_o;
    oe = host_data_out_en;
    {host_cs_n, host_rd_n, host_wr_n} <= 3'h7;
    host_data_lines <= ~d; // Released lines show no stale word
    repeat (4) @(posedge pclk);
  endtask
endmodule // hpio_host_model

// ===== test/tb_top.sv
// Self-checking testbench for the host port and I/O control block
`timescale 1ns/1ps
`include "hpio_consts.vh"
module tb_top;
  // Bench-driven inputs and results
  reg         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         fifo_pop = 1'b0, err, oe;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [15:0] addr_bus_i = 16'hbeef, status_in = 16'h0028, pc_in = 16'h0123, q, e [0:2];
  integer     fail_count = 0, samples_checked = 0, i;
  // Design outputs and host lines
  wire        pready, pslverr, host_cs_n, host_rd_n, host_wr_n, host_cmd_tag_line, host_data_out_en;
  wire        fifo_cmd_data_tag, fifo_out_ready, cmd_valid, fifo_input_ready;
  wire [4:0]  host_reg_select, fifo_reg_addr;
  wire [15:0] host_data_lines, host_data_o, addr_bus_o, fifo_data, out_ctrl_lines;
  wire [31:0] prdata;
  wire [9:0]  cmd_next_addr;
  hpio_top hpio_top_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .host_cs_n, .host_rd_n, .host_wr_n, .host_cmd_tag_line, .host_reg_select, .host_addr_o(),
    .host_addr_out_en(), .host_data_lines, .host_data_o, .host_data_out_en, .addr_bus_i, .addr_bus_o,
    .addr_bus_out_en(), .status_in, .pc_in, .fifo_pop, .fifo_data, .fifo_reg_addr, .fifo_cmd_data_tag,
    .fifo_out_ready, .cmd_next_addr, .cmd_valid, .fifo_input_ready, .out_ctrl_lines);
  hpio_host_model hpio_host_model_i (.pclk, .host_cs_n, .host_rd_n, .host_wr_n, .host_cmd_tag_line,
    .host_reg_select, .host_data_lines, .host_data_o, .host_data_out_en);
  // Clock
  always #25 pclk = ~pclk;
  // Compare and count
  task chk(input string n, input [31:0] x, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== x) begin
      $display("unexpected %s: expected %h seen %h", n, x, g);
      fail_count = fail_count + 1;
    end
  endtask
  // APB transfer, waits for pready
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  // Host strobe: r high means write, low means read
  task hc(input r, input t, input [4:0] s, input [15:0] d);
    hpio_host_model_i.cyc(r, !r, t, s, d, q, oe);
  endtask
  task wt(input integer n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task pop;
    @(posedge pclk);
    fifo_pop <= 1'b1;
    @(posedge pclk);
    fifo_pop <= 1'b0;
  endtask
  task tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    e[0] = 16'h1234;
    e[1] = 16'h012a;
    e[2] = 16'h0123;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `HPIO_OFF_STATUS, 0);
    chk("status", 32'h012a, rd);
    apb(0, 12'h040, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    apb(1, `HPIO_OFF_DOR, 32'h1234);
    apb(1, `HPIO_OFF_AOR, 32'h5a5a);
    apb(1, `HPIO_OFF_OUTCTL, 32'hc3c3);
    chk("out lines", 16'hc3c3, out_ctrl_lines);
    chk("addr bus", 16'h5a5a, addr_bus_o);
    hc(1, 0, 5'h07, 16'ha5c3);
    chk("entry", {1'b0, 5'h07, 16'ha5c3}, {fifo_cmd_data_tag, fifo_reg_addr, fifo_data});
    pop;
    hc(1, 1, 5'h1f, 16'h07ff);
    chk("cmd entry", {1'b1, 5'h00, 16'h07ff}, {fifo_cmd_data_tag, fifo_reg_addr, fifo_data});
    chk("cmd addr", {1'b1, 10'h3ff}, {cmd_valid, cmd_next_addr});
    pop;
    // Overfill, then clear from the host side
    for (i = 0; i < 9; i++) hc(1, 0, 5'h01, i[15:0]);
    chk("input ready", 0, fifo_input_ready);
    hc(0, 0, 5'h04, 16'h0000);
    chk("fifo clear", 3'b001, {oe, fifo_out_ready, fifo_input_ready});
    for (i = 0; i < 3; i++) begin
      hc(0, 0, i[4:0], 16'h0000);
      chk("host read", {1'b1, e[i]}, {oe, q});
    end
    hc(0, 0, 5'h03, 16'h0000);
    apb(0, `HPIO_OFF_STATUS, 0);
    chk("status clear", 0, {oe, rd[15:0]});
    hc(0, 1, 5'h00, 16'h0000);
    chk("tagged read", 0, oe);
    // Idle drive from each source, then direction off
    e[1] = 16'h0000;
    for (i = 1; i < 4; i++) begin
      apb(1, `HPIO_OFF_CTRL, (i << 5) | 32'h1c);
      wt(3);
      chk("idle drive", {1'b1, e[i - 1]}, {host_data_out_en, host_data_o});
    end
    apb(1, `HPIO_OFF_CTRL, 32'h060);
    wt(3);
    chk("drive off", 0, host_data_out_en);
    apb(1, `HPIO_OFF_CTRL, 32'h080);
    wt(2);
    apb(0, `HPIO_OFF_DATAIN, 0);
    chk("data in", 16'hffff, rd);
    apb(1, `HPIO_OFF_CTRL, 32'h100);
    wt(2);
    apb(0, `HPIO_OFF_ADDRIN, 0);
    chk("addr in", 16'hbeef, rd);
    apb(1, `HPIO_OFF_CTRL, 0);
    @(posedge pclk) addr_bus_i <= 16'h1111;
    wt(2);
    apb(0, `HPIO_OFF_ADDRIN, 0);
    chk("addr in held", 16'hbeef, rd);
    apb(1, `HPIO_OFF_ADDRCNT, 32'h0012_3456);
    apb(0, `HPIO_OFF_ADDRCNT, 0);
    chk("addr count", 32'h0012_3456, rd);
    // Block counter steps down on the three edges the enable is seen
    apb(1, `HPIO_OFF_BLKCNT, 32'h5);
    apb(1, `HPIO_OFF_CTRL, 32'h002);
    apb(1, `HPIO_OFF_CTRL, 0);
    apb(0, `HPIO_OFF_BLKCNT, 0);
    chk("block count", 32'h2, rd);
    // Counting, holding and joined counting
    apb(1, `HPIO_OFF_CTRL, 32'h201);
    wt(8);
    apb(1, `HPIO_OFF_CTRL, 32'h200);
    wt(4);
    apb(1, `HPIO_OFF_CTRL, 32'h601);
    wt(80);
    tally_and_finish;
  end
endmodule // tb_top
